// ### hdl/fwd_qual_pkg.sv
package fwd_qual_pkg;
  // Register offsets of the per-port copy.
  localparam logic [7:0] OFS_VIDEO_CFG = 8'h7C;
  localparam logic [7:0] OFS_QUAL_CTL = 8'h7D;
  localparam logic [7:0] OFS_RISE_MASK = 8'h7E;
  // Reset values.
  localparam logic [7:0] RST_VIDEO_CFG = 8'h20;
  localparam logic [7:0] RST_QUAL_CTL = 8'h00;
  localparam logic [7:0] RST_RISE_MASK = 8'h00;
  // Fields of port_video_config_two.
  localparam int PACK_HI = 7;
  localparam int PACK_LO = 6;
  localparam int TRUNC_PAR_BIT = 5;
  localparam int TRUNC_WIDTH_BIT = 4;
  localparam int TRUNC_HEIGHT_BIT = 3;
  localparam int ROW_POL_BIT = 1;
  localparam int FRAME_POL_BIT = 0;
  // Fields of port_forward_qualify_ctl.
  localparam int QUAL_DISCARD_BIT = 7;
  localparam int CHK_HEIGHT_BIT = 5;
  localparam int CHK_WIDTH_BIT = 4;
  localparam int PAR_MODE_BIT = 3;
  localparam int WD_OFF_BIT = 2;
  localparam int THR_HI = 1;
  localparam int THR_LO = 0;
  // Byte packing codes for ten-bit raw pixels.
  localparam logic [1:0] PACK_NORMAL = 2'h0;
  localparam logic [1:0] PACK_RSVD = 2'h1;
  localparam logic [1:0] PACK_UPPER = 2'h2;
  localparam logic [1:0] PACK_LOWER = 2'h3;
  // Pixel and sensor flag widths.
  localparam int PIX_W = 10;
  localparam int FLAG_W = 8;
  // Read-select field inside the port-select value.
  localparam int RD_SEL_HI = 5;
  localparam int RD_SEL_LO = 4;
  // Saturation value of the valid-frame counter.
  localparam logic [1:0] VF_MAX = 2'h3;
endpackage

// ### hdl/size_track_if.sv
`timescale 1ns/1ps
`default_nettype none
interface size_track_if;
  logic step;
  logic close;
  logic restart;
  logic changed;
  modport owner (output step, output close, output restart, input changed);
  modport tracker (input step, input close, input restart, output changed);
endinterface
`default_nettype wire

// ### hdl/size_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module size_tracker #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  size_track_if.tracker trk
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] ref_q;
  logic ref_ok_q;
  logic changed_q;
  wire [W-1:0] cnt_now = cnt_q + {{(W-1){1'b0}}, trk.step};

  generate
    if (W < 2) begin : g_bad_w
      $error("size_tracker width too small");
    end
  endgenerate

  // A size is compared only once a reference size has been seen.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      ref_q <= '0;
      ref_ok_q <= 1'b0;
      changed_q <= 1'b0;
    end else if (ce_in) begin
      if (trk.restart) begin
        cnt_q <= '0;
        ref_ok_q <= 1'b0;
        changed_q <= 1'b0;
      end else if (trk.close) begin
        changed_q <= ref_ok_q && (cnt_now != ref_q);
        ref_q <= cnt_now;
        ref_ok_q <= 1'b1;
        cnt_q <= '0;
      end else begin
        changed_q <= 1'b0;
        cnt_q <= cnt_now;
      end
    end
  end

  assign trk.changed = changed_q;
endmodule // size_tracker
`default_nettype wire

// ### hdl/rise_latch.sv
`timescale 1ns/1ps
`default_nettype none
module rise_latch #(
  parameter int N = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [N-1:0] flags_in,
  input wire logic [N-1:0] mask_in,
  input wire logic [N-1:0] clear_in,
  output logic [N-1:0] latched_out
);
  logic [N-1:0] prev_q;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      wire rise = flags_in[i] && !prev_q[i] && mask_in[i];
      // A rise in the clearing cycle keeps the bit set.
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          prev_q[i] <= 1'b0;
          latched_out[i] <= 1'b0;
        end else if (ce_in) begin
          prev_q[i] <= flags_in[i];
          latched_out[i] <= rise || (latched_out[i] && !clear_in[i]);
        end
      end
    end
  endgenerate
endmodule // rise_latch
`default_nettype wire

// ### hdl/rx_port_forward_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
module rx_port_forward_qualifier
  import fwd_qual_pkg::*;
#(
  parameter int PORT_INDEX = 0,
  parameter int WIDTH_W = 16,
  parameter int HEIGHT_W = 16,
  parameter int PERIOD_W = 24
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] port_sel_in,
  output logic [7:0] reg_rdata_out,
  input wire logic rx_lock_in,
  input wire logic parity_err_in,
  input wire logic frame_marker_in,
  input wire logic row_marker_in,
  input wire logic raw_ten_in,
  input wire logic [fwd_qual_pkg::PIX_W-1:0] pix_in,
  input wire logic [fwd_qual_pkg::FLAG_W-1:0] remote_sensor_flags_in,
  input wire logic [fwd_qual_pkg::FLAG_W-1:0] sensor_rise_clear_in,
  output logic [fwd_qual_pkg::PIX_W-1:0] pix_data_out,
  output logic pix_valid_out,
  output logic qualify_out,
  output logic frame_drop_out,
  output logic [fwd_qual_pkg::FLAG_W-1:0] sensor_rise_latched_out
);
  import fwd_qual_pkg::*;

  generate
    if (PORT_INDEX < 0 || PORT_INDEX > 3) begin : g_bad_port
      $error("PORT_INDEX must be 0 to 3");
    end
    if (PERIOD_W < 4) begin : g_bad_period
      $error("PERIOD_W too small");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] video_cfg_q;
  logic [7:0] qual_ctl_q;
  logic [7:0] rise_mask_q;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  wire wr_sel = port_sel_in[PORT_INDEX];
  wire rd_sel = port_sel_in[RD_SEL_HI:RD_SEL_LO] == 2'(PORT_INDEX);
  wire wr_cfg = reg_wr_in && wr_sel && hit(reg_addr_in, OFS_VIDEO_CFG);
  wire wr_ctl = reg_wr_in && wr_sel && hit(reg_addr_in, OFS_QUAL_CTL);
  wire wr_mask = reg_wr_in && wr_sel && hit(reg_addr_in, OFS_RISE_MASK);
  wire [7:0] rd_mux = hit(reg_addr_in, OFS_VIDEO_CFG) ? video_cfg_q :
                      hit(reg_addr_in, OFS_QUAL_CTL) ? qual_ctl_q :
                      hit(reg_addr_in, OFS_RISE_MASK) ? rise_mask_q : 8'h00;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      video_cfg_q <= RST_VIDEO_CFG;
      qual_ctl_q <= RST_QUAL_CTL;
      rise_mask_q <= RST_RISE_MASK;
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      if (wr_cfg) video_cfg_q <= reg_wdata_in;
      if (wr_ctl) qual_ctl_q <= reg_wdata_in;
      if (wr_mask) rise_mask_q <= reg_wdata_in;
      if (reg_rd_in) reg_rdata_out <= rd_sel ? rd_mux : 8'h00;
    end
  end

  wire [1:0] pack_sel = video_cfg_q[PACK_HI:PACK_LO];
  wire trunc_par = video_cfg_q[TRUNC_PAR_BIT];
  wire trunc_width = video_cfg_q[TRUNC_WIDTH_BIT];
  wire trunc_height = video_cfg_q[TRUNC_HEIGHT_BIT];
  wire row_pol = video_cfg_q[ROW_POL_BIT];
  wire frame_pol = video_cfg_q[FRAME_POL_BIT];
  wire qual_discard = qual_ctl_q[QUAL_DISCARD_BIT];
  wire chk_height = qual_ctl_q[CHK_HEIGHT_BIT];
  wire chk_width = qual_ctl_q[CHK_WIDTH_BIT];
  wire par_mode = qual_ctl_q[PAR_MODE_BIT];
  wire wd_off = qual_ctl_q[WD_OFF_BIT];
  wire [1:0] thr = qual_ctl_q[THR_HI:THR_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Marker decode and frame tracking.

  // A marker bit of one in the polarity field means active low.
  wire frame_act = frame_marker_in ^ frame_pol;
  wire row_act = (row_marker_in ^ row_pol) && frame_act;

  logic frame_act_q;
  logic row_act_q;
  logic frame_end_q;
  wire frame_start = frame_act && !frame_act_q;
  wire frame_end = !frame_act && frame_act_q;
  wire row_end = !row_act && row_act_q;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      frame_act_q <= 1'b0;
      row_act_q <= 1'b0;
      frame_end_q <= 1'b0;
    end else if (ce_in) begin
      frame_act_q <= frame_act;
      row_act_q <= row_act;
      frame_end_q <= frame_end;
    end
  end

  size_track_if width_if ();
  size_track_if height_if ();

  assign width_if.step = row_act;
  assign width_if.close = row_end;
  assign width_if.restart = !rx_lock_in;
  assign height_if.step = row_end;
  assign height_if.close = frame_end;
  assign height_if.restart = !rx_lock_in;

  size_tracker #(.W(WIDTH_W)) u_width (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .trk(width_if.tracker)
  );

  size_tracker #(.W(HEIGHT_W)) u_height (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .trk(height_if.tracker)
  );

  wire width_chg = width_if.changed;
  wire height_chg = height_if.changed;

  ////////////////////////////////////////////////////////////////////////////
  // Frame-end watchdog.

  logic [PERIOD_W-1:0] wd_cnt_q;
  logic [PERIOD_W-1:0] period_q;
  wire [PERIOD_W-1:0] wd_limit = {period_q[PERIOD_W-2:0], 1'b0};
  wire wd_timeout = (period_q != '0) && (wd_cnt_q == wd_limit);
  wire wd_hit = wd_timeout && !wd_off && (thr != 2'h0);

  // The period is the last frame-end to frame-end distance; the counter
  // saturates so that a stalled link does not wrap into a false match.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wd_cnt_q <= '0;
      period_q <= '0;
    end else if (ce_in) begin
      if (!rx_lock_in) begin
        wd_cnt_q <= '0;
        period_q <= '0;
      end else if (frame_end) begin
        period_q <= wd_cnt_q;
        wd_cnt_q <= '0;
      end else if (wd_cnt_q != '1) begin
        wd_cnt_q <= wd_cnt_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Qualification.

  logic err_q;
  logic [1:0] vf_q;
  logic hold_q;
  logic drop_q;

  wire height_evt = chk_height && height_chg;
  wire width_evt = chk_width && width_chg;
  wire frame_bad = err_q || parity_err_in || height_evt || width_evt;
  wire qual_clr = !rx_lock_in
                  || height_evt
                  || width_evt
                  || (parity_err_in && par_mode)
                  || wd_hit
                  || (trunc_height && height_chg);
  wire thr_met = (thr == 2'h0) || (vf_q >= thr);
  wire qual_d = rx_lock_in && thr_met && !qual_clr && !(parity_err_in && !par_mode);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      err_q <= 1'b0;
      vf_q <= 2'h0;
      qualify_out <= 1'b0;
    end else if (ce_in) begin
      qualify_out <= qual_d;
      if (parity_err_in || width_evt) begin
        err_q <= 1'b1;
      end else if (frame_start) begin
        err_q <= 1'b0;
      end
      if (qual_clr) begin
        vf_q <= 2'h0;
      end else if (frame_end_q && !frame_bad && vf_q != VF_MAX) begin
        vf_q <= vf_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Truncation and forwarding.

  wire drop_set = (trunc_par && parity_err_in)
                  || (trunc_width && width_chg)
                  || (trunc_height && height_chg);
  wire hold_set = trunc_height && height_chg;
  wire fwd_ok = !drop_q && !drop_set && !hold_q && !(qual_discard && !qualify_out);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      drop_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (ce_in) begin
      drop_q <= drop_set || (drop_q && !frame_start);
      hold_q <= hold_set || (hold_q && !qualify_out);
    end
  end

  assign frame_drop_out = drop_q;

  // Byte packing keeps one byte of the ten-bit pixel in the low bits.
  wire [7:0] pix_upper = pix_in[PIX_W-1:PIX_W-8];
  wire [7:0] pix_lower = pix_in[7:0];
  wire [PIX_W-1:0] pix_packed = !raw_ten_in ? pix_in :
                                (pack_sel == PACK_UPPER) ? {2'b00, pix_upper} :
                                (pack_sel == PACK_LOWER) ? {2'b00, pix_lower} :
                                pix_in;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pix_data_out <= '0;
      pix_valid_out <= 1'b0;
    end else if (ce_in) begin
      pix_data_out <= pix_packed;
      pix_valid_out <= row_act && fwd_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sensor flag rising-edge latch.

  rise_latch #(.N(FLAG_W)) u_rise (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .flags_in(remote_sensor_flags_in),
    .mask_in(rise_mask_q),
    .clear_in(sensor_rise_clear_in),
    .latched_out(sensor_rise_latched_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in || !ce_in);

  a_pack_upper: assert property (
    (raw_ten_in && pack_sel == PACK_UPPER) |=> pix_data_out == {2'b00, $past(pix_upper)})
    else $error("upper byte packing wrong");

  a_pack_lower: assert property (
    (raw_ten_in && pack_sel == PACK_LOWER) |=> pix_data_out == {2'b00, $past(pix_lower)})
    else $error("lower byte packing wrong");

  a_parity_trunc: assert property (
    (parity_err_in && trunc_par) |=> !pix_valid_out && frame_drop_out)
    else $error("parity error did not truncate");

  a_width_trunc: assert property (
    (trunc_width && width_chg) |=> !pix_valid_out)
    else $error("line size change not truncated");

  a_height_hold: assert property (
    (trunc_height && height_chg) |=> !pix_valid_out && !qualify_out)
    else $error("frame size change not truncated");

  a_row_idle: assert property (
    (row_marker_in == row_pol) |=> !pix_valid_out)
    else $error("forwarded outside active row");

  a_frame_idle: assert property (
    (frame_marker_in == frame_pol) |=> !pix_valid_out)
    else $error("forwarded outside active frame");

  a_discard_gate: assert property (
    (qual_discard && !qualify_out) |=> !pix_valid_out)
    else $error("forwarded while unqualified");

  a_height_qual: assert property (
    (chk_height && height_chg) |=> !qualify_out)
    else $error("line count change kept qualification");

  a_width_qual: assert property (
    (chk_width && width_chg) |=> !qualify_out)
    else $error("line size change kept qualification");

  a_parity_dip: assert property (
    parity_err_in |=> !qualify_out)
    else $error("parity error kept qualification");

  a_parity_hold: assert property (
    (parity_err_in && par_mode && thr != 2'h0 && !wr_ctl) |=> !qualify_out [*2])
    else $error("qualification back too soon after parity");

  a_wd_clear: assert property (
    (wd_timeout && !wd_off && thr != 2'h0) |=> !qualify_out)
    else $error("watchdog did not clear qualification");

  a_thr_zero: assert property (
    (rx_lock_in && thr == 2'h0 && !qual_clr && !parity_err_in) |=> qualify_out)
    else $error("threshold zero did not qualify on lock");

  a_rise_latch: assert property (
    ($rose(remote_sensor_flags_in[0]) && rise_mask_q[0]) |=> sensor_rise_latched_out[0])
    else $error("masked rising flag not latched");

  a_sel_write: assert property (
    (wr_ctl) |=> qual_ctl_q == $past(reg_wdata_in))
    else $error("selected port write lost");

  a_unsel_write: assert property (
    (reg_wr_in && !wr_sel) |=> $stable(video_cfg_q) && $stable(qual_ctl_q))
    else $error("unselected port took a write");

  a_lock_loss: assert property (
    !rx_lock_in |=> !qualify_out && vf_q == 2'h0)
    else $error("lock loss kept qualification");

  c_qualify: cover property ($rose(qualify_out));
  c_truncate: cover property ($rose(frame_drop_out));
  c_forward: cover property (pix_valid_out && qualify_out);
  c_rise: cover property ($rose(sensor_rise_latched_out[0]));
endmodule // rx_port_forward_qualifier
`default_nettype wire

// ### verif/serializer_model.sv
`timescale 1ns/1ps
`default_nettype none
module serializer_model (
  input wire logic clk_in,
  input wire logic row_pol_in,
  input wire logic frame_pol_in,
  output logic lock_out,
  output logic parity_err_out,
  output logic frame_marker_out,
  output logic row_marker_out,
  output logic [fwd_qual_pkg::PIX_W-1:0] pix_out
);
  import fwd_qual_pkg::*;
  logic [PIX_W-1:0] pix_value;
  logic [PIX_W-1:0] idle_q;
  logic row_on;
  logic frame_on;

  initial begin
    lock_out = 1'b0;
    parity_err_out = 1'b0;
    row_on = 1'b0;
    frame_on = 1'b0;
    pix_value = 10'h155;
    idle_q = 10'h0F0;
  end

  // Pixel lines outside a row toggle every cycle so stale data cannot pass for a pixel.
  always @(posedge clk_in) begin
    idle_q <= ~idle_q;
  end
  assign pix_out = row_on ? pix_value : idle_q;
  assign frame_marker_out = frame_on ^ frame_pol_in;
  assign row_marker_out = row_on ^ row_pol_in;

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask

  // Row 1 may carry a different length; a parity error can be placed on the first pixel of a row.
  task automatic send_frame(input int rows, input int cols, input int alt, input int par_row);
    frame_on = 1'b1;
    step(2);
    for (int r = 0; r < rows; r++) begin
      row_on = 1'b1;
      parity_err_out = (r == par_row);
      step(1);
      parity_err_out = 1'b0;
      step(((r == 1) ? alt : cols) - 1);
      row_on = 1'b0;
      step(2);
    end
    frame_on = 1'b0;
    step(3);
  endtask

  task automatic pulse_parity();
    parity_err_out = 1'b1;
    step(1);
    parity_err_out = 1'b0;
  endtask
endmodule // serializer_model
`default_nettype wire

// ### verif/rx_port_forward_qualifier_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rx_port_forward_qualifier_tb_top;
  import fwd_qual_pkg::*;
  logic clk, rst_n, ce, reg_wr, reg_rd, raw_ten, lock, par_err, fm, rm, row_pol, frame_pol;
  logic pix_valid, qualify, frame_drop;
  logic [7:0] reg_addr, reg_wdata, port_sel, reg_rdata, flags, rise_clr, rise_latched;
  logic [PIX_W-1:0] pix, pix_data, last_pix;
  int n_errors = 0;
  int checks = 0;
  int fwd_cnt = 0;
  logic [PIX_W-1:0] pack_exp [4] = '{10'h2B5, 10'h2B5, 10'h0AD, 10'h0B5};

  rx_port_forward_qualifier #(.PERIOD_W(10)) u_dut (.core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .port_sel_in(port_sel), .reg_rdata_out(reg_rdata), .rx_lock_in(lock), .parity_err_in(par_err),
    .frame_marker_in(fm), .row_marker_in(rm), .raw_ten_in(raw_ten), .pix_in(pix),
    .remote_sensor_flags_in(flags), .sensor_rise_clear_in(rise_clr), .pix_data_out(pix_data),
    .pix_valid_out(pix_valid), .qualify_out(qualify), .frame_drop_out(frame_drop),
    .sensor_rise_latched_out(rise_latched));
  serializer_model u_far (.clk_in(clk), .row_pol_in(row_pol), .frame_pol_in(frame_pol), .lock_out(lock),
    .parity_err_out(par_err), .frame_marker_out(fm), .row_marker_out(rm), .pix_out(pix));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Forwarded pixels are counted mid-cycle, where the registered outputs have settled.
  always @(negedge clk) begin
    if (pix_valid === 1'b1) begin
      fwd_cnt++;
      last_pix = pix_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk("reg_rdata", {2'b00, exp}, {2'b00, reg_rdata});
    tick(1);
  endtask

  task automatic frame(input int rows, input int cols, input int alt, input int par_row);
    fwd_cnt = 0;
    u_far.send_frame(rows, cols, alt, par_row);
  endtask

  task automatic qual(input logic e);
    chk("qualify", {9'h000, e}, {9'h000, qualify});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    n_errors++;
    close_out();
  end

  initial begin
    logic [1:0] p;
    {rst_n, reg_wr, reg_rd, raw_ten, row_pol, frame_pol} = '0;
    {reg_addr, reg_wdata, flags, rise_clr} = '0;
    ce = 1'b1;
    port_sel = 8'h01;
    tick(2);
    rst_n = 1'b1;
    reg_read(8'h7C, 8'h20);
    reg_read(8'h7D, 8'h00);
    reg_read(8'h7E, 8'h00);
    reg_read(8'h7F, 8'h00);
    port_sel = 8'h12;
    reg_write(8'h7E, 8'hFF);
    reg_read(8'h7E, 8'h00);
    port_sel = 8'h01;
    reg_read(8'h7E, 8'h00);
    reg_write(8'h7E, 8'hA5);
    reg_read(8'h7E, 8'hA5);
    u_far.lock_out = 1'b1;
    tick(2);
    qual(1'b1);
    u_far.lock_out = 1'b0;
    tick(2);
    qual(1'b0);
    u_far.lock_out = 1'b1;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i + 1);
      reg_write(8'h7C, {6'h08, p});
      {row_pol, frame_pol} = p;
      tick(3);
      frame(2, 4, 4, -1);
      chk("fwd_cnt", 10'd8, 10'(fwd_cnt));
    end
    raw_ten = 1'b1;
    u_far.pix_value = 10'h2B5;
    reg_write(8'h70, 8'h2A);
    for (int k = 0; k < 4; k++) begin
      reg_write(8'h7C, {2'(k), 6'h20});
      frame(1, 2, 2, -1);
      chk("pix_data", pack_exp[k], last_pix);
    end
    raw_ten = 1'b0;
    reg_write(8'h7C, 8'h20);
    frame(3, 4, 4, 1);
    chk("parity_trunc", 10'd4, 10'(fwd_cnt));
    chk("frame_drop", 10'h001, {9'h000, frame_drop});
    reg_write(8'h7C, 8'h00);
    frame(3, 4, 4, 1);
    chk("fwd_cnt", 10'd12, 10'(fwd_cnt));
    chk("frame_drop", 10'h000, {9'h000, frame_drop});
    reg_write(8'h7C, 8'h10);
    frame(3, 4, 6, -1);
    chk("size_trunc", 10'd10, 10'(fwd_cnt));
    reg_write(8'h7C, 8'h00);
    frame(3, 4, 6, -1);
    chk("fwd_cnt", 10'd14, 10'(fwd_cnt));
    reg_write(8'h7C, 8'h28);
    reg_write(8'h7D, 8'h21);
    frame(2, 4, 4, -1);
    frame(2, 4, 4, -1);
    qual(1'b1);
    frame(3, 4, 4, -1);
    qual(1'b0);
    frame(3, 4, 4, -1);
    chk("fwd_cnt", 10'd0, 10'(fwd_cnt));
    qual(1'b1);
    frame(3, 4, 4, -1);
    chk("fwd_cnt", 10'd12, 10'(fwd_cnt));
    reg_write(8'h7C, 8'h20);
    reg_write(8'h7D, 8'h11);
    frame(2, 4, 4, -1);
    frame(2, 4, 4, -1);
    frame(2, 6, 6, -1);
    qual(1'b0);
    frame(2, 6, 6, -1);
    qual(1'b1);
    reg_write(8'h7D, 8'h0A);
    repeat (3) frame(2, 4, 4, -1);
    frame(2, 4, 4, 0);
    qual(1'b0);
    frame(2, 4, 4, -1);
    qual(1'b0);
    frame(2, 4, 4, -1);
    qual(1'b1);
    reg_write(8'h7D, 8'h01);
    u_far.pulse_parity();
    qual(1'b0);
    tick(1);
    qual(1'b1);
    reg_write(8'h7D, 8'h82);
    u_far.lock_out = 1'b0;
    tick(2);
    u_far.lock_out = 1'b1;
    frame(2, 4, 4, -1);
    chk("fwd_cnt", 10'd0, 10'(fwd_cnt));
    frame(2, 4, 4, -1);
    chk("fwd_cnt", 10'd0, 10'(fwd_cnt));
    frame(2, 4, 4, -1);
    chk("fwd_cnt", 10'd8, 10'(fwd_cnt));
    reg_write(8'h7D, 8'h01);
    frame(2, 4, 4, -1);
    frame(2, 4, 4, -1);
    tick(200);
    qual(1'b0);
    reg_write(8'h7D, 8'h00);
    frame(2, 4, 4, -1);
    frame(2, 4, 4, -1);
    tick(200);
    qual(1'b1);
    reg_write(8'h7D, 8'h05);
    frame(2, 4, 4, -1);
    frame(2, 4, 4, -1);
    tick(200);
    qual(1'b1);
    reg_write(8'h7E, 8'h05);
    flags = 8'h0F;
    tick(2);
    chk("rise_latched", 10'h005, {2'b00, rise_latched});
    flags = 8'h00;
    rise_clr = 8'hFF;
    tick(1);
    rise_clr = 8'h00;
    tick(1);
    chk("rise_latched", 10'h000, {2'b00, rise_latched});
    ce = 1'b0;
    reg_write(8'h7E, 8'hFF);
    ce = 1'b1;
    reg_read(8'h7E, 8'h05);
    close_out();
  end
endmodule // rx_port_forward_qualifier_tb_top
`default_nettype wire
